// ===== verilog/irc_engine.sv
// Input-driven register copy engine with APB access to the register file
//
// Register access over APB was chosen for this implementation.
`include "irc_defs.svh"

module irc_engine import irc_pkg::*; #(
   parameter int          ADDR_W      = 12,
   parameter int          IN_W        = 16,
   parameter int          TICK_CYCLES = `IRC_TICK_CYCLES,
   parameter int          GROUP_LEN   = 8,
   // Register numbers of the fixed targets
   parameter irc_regnum_t MODE_NUM    = 8'h02,
   parameter irc_regnum_t VEL_NUM     = 8'h05,
   parameter irc_regnum_t POS_NUM     = 8'h03,
   parameter irc_regnum_t ACC_NUM     = 8'h06,
   parameter irc_regnum_t TORQUE_NUM  = 8'h07,
   parameter irc_regnum_t INPOS_NUM   = 8'h21,
   // Group base: index k selects register base + k
   parameter irc_regnum_t MODE_BASE   = 8'h58,
   parameter irc_regnum_t VEL_BASE    = 8'h70,
   parameter irc_regnum_t POS_BASE    = 8'h30,
   parameter irc_regnum_t ACC_BASE    = 8'h78,
   parameter irc_regnum_t TORQUE_BASE = 8'h80,
   parameter irc_regnum_t INPOS_BASE  = 8'h88
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Digital input levels
   input  wire logic [IN_W-1:0]   input_state,
   // Engine status and copy events
   output logic                   pass_busy,
   output logic                   copy_valid,
   output logic      [7:0]        copy_reg,
   output logic      [31:0]       copy_data
);

   localparam int CNT_W = $clog2(TICK_CYCLES);

   // Classify a register number by where it is stored
   function automatic irc_kind_e reg_kind(input irc_regnum_t num);
      if (num >= `IRC_RULE_FIRST && num <= `IRC_RULE_LAST) begin
         reg_kind = IRC_KIND_RULE;
      end else if (num == `IRC_INPUT_STATE_REG) begin
         reg_kind = IRC_KIND_INPUT;
      end else begin
         reg_kind = IRC_KIND_MEM;
      end
   endfunction

   // Fixed target register of a target code
   function automatic irc_regnum_t tgt_of(input logic [3:0] code);
      case (code)
         `IRC_TGT_MODE:   tgt_of = MODE_NUM;
         `IRC_TGT_VEL:    tgt_of = VEL_NUM;
         `IRC_TGT_POS:    tgt_of = POS_NUM;
         `IRC_TGT_ACC:    tgt_of = ACC_NUM;
         `IRC_TGT_TORQUE: tgt_of = TORQUE_NUM;
         `IRC_TGT_INPOS:  tgt_of = INPOS_NUM;
         default:         tgt_of = `IRC_NO_COPY;
      endcase
   endfunction

   // Source group base of a target code
   function automatic irc_regnum_t base_of(input logic [3:0] code);
      case (code)
         `IRC_TGT_MODE:   base_of = MODE_BASE;
         `IRC_TGT_VEL:    base_of = VEL_BASE;
         `IRC_TGT_POS:    base_of = POS_BASE;
         `IRC_TGT_ACC:    base_of = ACC_BASE;
         `IRC_TGT_TORQUE: base_of = TORQUE_BASE;
         `IRC_TGT_INPOS:  base_of = INPOS_BASE;
         default:         base_of = `IRC_NO_COPY;
      endcase
   endfunction

   // State
   irc_state_e        state_reg;
   irc_state_e        state_next;
   logic [3:0]        idx_reg;
   logic [3:0]        idx_next;
   irc_regnum_t       tgt_reg;
   logic [IN_W-1:0]   inputs_reg;
   logic [CNT_W-1:0]  cnt_reg;
   logic              tick_pend_reg;
   logic              rd_wait_reg;
   irc_kind_e         rd_kind_reg;
   irc_word_t         rd_aux_reg;
   irc_word_t         rules_reg [0:`IRC_RULE_COUNT-1];
   logic              copy_valid_reg;
   irc_regnum_t       copy_reg_reg;
   irc_word_t         copy_data_reg;

   // APB decode
   wire               apb_acc;
   wire               apb_bad;
   wire irc_regnum_t  apb_num;
   wire               busy;
   wire               apb_wr;
   wire               rd_wait_next;

   assign apb_acc = psel & penable;
   assign apb_num = paddr[9:2];
   assign apb_bad = |paddr[ADDR_W-1:10];
   assign busy    = (state_reg != IRC_ST_IDLE);

   // Accesses stall while a pass runs, so none lands mid-pass
   assign pready  = apb_acc & ~busy & (pwrite | apb_bad | rd_wait_reg);
   assign pslverr = pready & apb_bad;
   assign apb_wr  = pready & pwrite & ~apb_bad;
   // Reads need one cycle for the registered memory output
   assign rd_wait_next = apb_acc & ~pwrite & ~apb_bad & ~busy & ~rd_wait_reg;

   // Periodic tick
   wire tick_wrap;
   wire pass_start;
   assign tick_wrap  = (cnt_reg == CNT_W'(TICK_CYCLES - 1));
   // Wait for an APB access phase to finish before taking the bus
   assign pass_start = tick_pend_reg & ~apb_acc & ~busy;

   // Current rule decode
   wire irc_word_t    cur_rule;
   wire [3:0]         cur_code;
   wire [3:0]         cur_bit;
   wire               cur_lvl;
   wire irc_regnum_t  cur_src;
   wire irc_regnum_t  cur_dest;
   wire               grp_code;
   wire               grp_ok;
   wire               ind_ok;
   wire               eval_hit;
   wire irc_regnum_t  eval_src;
   wire irc_regnum_t  eval_tgt;

   assign cur_rule = rules_reg[idx_reg];
   assign cur_code = cur_rule[`IRC_TGT_HI:`IRC_TGT_LO];
   assign cur_bit  = cur_rule[`IRC_BIT_HI:`IRC_BIT_LO];
   // Any rule may read any bit, bits are shared freely
   assign cur_lvl  = inputs_reg[cur_bit];
   assign cur_src  = cur_lvl ? cur_rule[`IRC_SRC1_HI:`IRC_SRC1_LO]
                             : cur_rule[`IRC_SRC0_HI:`IRC_SRC0_LO];
   assign cur_dest = cur_rule[`IRC_DEST_HI:`IRC_DEST_LO];
   assign grp_code = (cur_code >= `IRC_TGT_MODE)
                   & (cur_code <= `IRC_TGT_INPOS);
   // Zero index copies nothing; indices past the group are ignored too
   assign grp_ok   = grp_code & (cur_src != `IRC_NO_COPY)
                   & (cur_src <= 8'(GROUP_LEN));
   assign ind_ok   = (cur_code == `IRC_TGT_INDIRECT)
                   & (cur_src != `IRC_NO_COPY)
                   & (cur_src <= `IRC_REG_NUM_MAX)
                   & (cur_dest != `IRC_NO_COPY)
                   & (cur_dest != `IRC_INPUT_STATE_REG)
                   & (cur_dest <= `IRC_REG_NUM_MAX);
   assign eval_hit = grp_ok | ind_ok;
   assign eval_src = ind_ok ? cur_src
                            : 8'(base_of(cur_code) + cur_src);
   assign eval_tgt = ind_ok ? cur_dest : tgt_of(cur_code);

   // Shared read path: engine owns it during a pass, APB otherwise
   wire irc_regnum_t  rd_num;
   wire irc_kind_e    rd_kind;
   wire irc_word_t    mem_rdata;
   wire irc_word_t    read_data;
   wire [3:0]         rd_ridx;

   assign rd_num    = busy ? eval_src : apb_num;
   assign rd_kind   = reg_kind(rd_num);
   assign rd_ridx   = 4'(rd_num - `IRC_RULE_FIRST);
   assign read_data = (rd_kind_reg == IRC_KIND_MEM) ? mem_rdata : rd_aux_reg;

   // Shared write path
   wire               wr_en;
   wire irc_regnum_t  wr_num;
   wire irc_word_t    wr_data;
   wire irc_kind_e    wr_kind;
   wire               mem_we;

   assign wr_en   = busy ? (state_reg == IRC_ST_COPY) : apb_wr;
   assign wr_num  = busy ? tgt_reg : apb_num;
   assign wr_data = busy ? read_data : pwdata;
   assign wr_kind = reg_kind(wr_num);
   // Input state is read-only; writes to it are dropped
   assign mem_we  = wr_en & (wr_kind == IRC_KIND_MEM);

   irc_reg_mem #(
      .DW (32),
      .AW (8)
   ) u_mem (
      .pclk  (pclk),
      .we    (mem_we),
      .waddr (wr_num),
      .wdata (wr_data),
      .raddr (rd_num),
      .rdata (mem_rdata)
   );

   // Rule registers, one per rule, at consecutive numbers
   genvar g;
   generate
      for (g = 0; g < `IRC_RULE_COUNT; g++) begin : gen_rule
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               rules_reg[g] <= `IRC_RULE_RESET;
            end else if (wr_en && wr_kind == IRC_KIND_RULE &&
                         wr_num == 8'(`IRC_RULE_FIRST + g)) begin
               rules_reg[g] <= wr_data;
            end
         end
      end
   endgenerate

   // Sequencer: one rule per EVAL, optional COPY right after
   always_comb begin
      state_next = state_reg;
      idx_next   = idx_reg;
      case (state_reg)
         IRC_ST_IDLE: begin
            if (pass_start) begin
               state_next = IRC_ST_EVAL;
               idx_next   = 4'h0;
            end
         end
         IRC_ST_EVAL: begin
            if (eval_hit) begin
               state_next = IRC_ST_COPY;
            end else if (idx_reg == 4'(`IRC_RULE_COUNT - 1)) begin
               state_next = IRC_ST_IDLE;
            end else begin
               idx_next = idx_reg + 4'h1;
            end
         end
         IRC_ST_COPY: begin
            // Write lands before the next rule reads, so later wins
            if (idx_reg == 4'(`IRC_RULE_COUNT - 1)) begin
               state_next = IRC_ST_IDLE;
            end else begin
               state_next = IRC_ST_EVAL;
               idx_next   = idx_reg + 4'h1;
            end
         end
         default: begin
            state_next = IRC_ST_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= IRC_ST_IDLE;
         idx_reg   <= 4'h0;
         tgt_reg   <= 8'h00;
      end else begin
         state_reg <= state_next;
         idx_reg   <= idx_next;
         if (state_reg == IRC_ST_EVAL) begin
            tgt_reg <= eval_tgt;
         end
      end
   end

   // Inputs caught once per pass so every rule sees the same levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inputs_reg <= '0;
      end else if (pass_start) begin
         inputs_reg <= input_state;
      end
   end

   // Free-running period counter; a tick waiting for the bus is kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg       <= '0;
         tick_pend_reg <= 1'b0;
      end else begin
         cnt_reg       <= tick_wrap ? '0 : cnt_reg + 1'b1;
         tick_pend_reg <= tick_wrap | (tick_pend_reg & ~pass_start);
      end
   end

   // Read side: kind and non-memory data registered with the address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_wait_reg <= 1'b0;
         rd_kind_reg <= IRC_KIND_MEM;
         rd_aux_reg  <= 32'h0000_0000;
      end else begin
         rd_wait_reg <= rd_wait_next;
         rd_kind_reg <= rd_kind;
         if (rd_kind == IRC_KIND_RULE) begin
            rd_aux_reg <= rules_reg[rd_ridx];
         end else begin
            // Pass reads see the sampled levels, idle reads live ones
            rd_aux_reg <= 32'(busy ? inputs_reg : input_state);
         end
      end
   end

   // Copy event report
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         copy_valid_reg <= 1'b0;
         copy_reg_reg   <= 8'h00;
         copy_data_reg  <= 32'h0000_0000;
      end else begin
         copy_valid_reg <= (state_reg == IRC_ST_COPY);
         if (state_reg == IRC_ST_COPY) begin
            copy_reg_reg  <= tgt_reg;
            copy_data_reg <= read_data;
         end
      end
   end

   // Outputs
   assign prdata     = read_data;
   assign pass_busy  = busy;
   assign copy_valid = copy_valid_reg;
   assign copy_reg   = copy_reg_reg;
   assign copy_data  = copy_data_reg;

endmodule

// ===== verilog/irc_defs.svh
// Offsets, field positions, reset values and timing counts of the copy engine
`ifndef IRC_DEFS_SVH
`define IRC_DEFS_SVH

// Register numbers in the motor register file (byte address = number * 4)
`define IRC_RULE_FIRST      8'h5d
`define IRC_RULE_LAST       8'h68
`define IRC_RULE_COUNT      12
`define IRC_INPUT_STATE_REG 8'h6a
`define IRC_REG_NUM_MAX     8'hfe

// Rule word field positions
`define IRC_DEST_HI   31
`define IRC_DEST_LO   24
`define IRC_SRC1_HI   23
`define IRC_SRC1_LO   16
`define IRC_SRC0_HI   15
`define IRC_SRC0_LO   8
`define IRC_BIT_HI    7
`define IRC_BIT_LO    4
`define IRC_TGT_HI    3
`define IRC_TGT_LO    0

// Target selection codes
`define IRC_TGT_NONE     4'h0
`define IRC_TGT_MODE     4'h1
`define IRC_TGT_VEL      4'h2
`define IRC_TGT_POS      4'h3
`define IRC_TGT_ACC      4'h4
`define IRC_TGT_TORQUE   4'h5
`define IRC_TGT_INPOS    4'h6
`define IRC_TGT_INDIRECT 4'h7

// Reset values
`define IRC_RULE_RESET   32'h0000_0000
`define IRC_NO_COPY      8'h00

// Timing: pass period in ns, clock period in ns, derived cycle count
`define IRC_CLK_PERIOD_NS 40
`define IRC_PASS_PERIOD_NS 1300000
`define IRC_TICK_CYCLES (`IRC_PASS_PERIOD_NS / `IRC_CLK_PERIOD_NS)

`endif

// ===== verilog/irc_pkg.sv
// Types shared by the input-driven register copy engine
package irc_pkg;

   // Engine sequencer states
   typedef enum logic [1:0] {
      IRC_ST_IDLE,
      IRC_ST_EVAL,
      IRC_ST_COPY
   } irc_state_e;

   // Where a register number lives
   typedef enum logic [1:0] {
      IRC_KIND_MEM,
      IRC_KIND_RULE,
      IRC_KIND_INPUT
   } irc_kind_e;

   typedef logic [7:0]  irc_regnum_t;
   typedef logic [31:0] irc_word_t;

endpackage

// ===== verilog/irc_reg_mem.sv
// Motor register file storage: one write port, one registered read port
module irc_reg_mem #(
   parameter int DW = 32,
   parameter int AW = 8
) (
   // Clock
   input  wire logic          pclk,
   // Write port
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   // Read port
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // No reset on the array; contents are undefined until written
   always_ff @(posedge pclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end

endmodule

// ===== test/irc_engine_checker.sv
// Port assertions for the register copy engine
module irc_engine_checker #(
   parameter int ADDR_W      = 12,
   parameter int IN_W        = 16,
   parameter int TICK_CYCLES = 64
) (
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // APB
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   // Inputs and engine status
   input wire logic [IN_W-1:0]   input_state,
   input wire logic              pass_busy,
   input wire logic              copy_valid,
   input wire logic [7:0]        copy_reg
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Error space and pass spacing helpers
   logic        bad_a;
   logic        busy_reg;
   logic [15:0] gap_reg;
   logic [15:0] gap_next;
   assign bad_a = paddr[ADDR_W-1 -: 2] != 2'b00;
   assign gap_next = (pass_busy && !busy_reg) ? 16'h0000 : gap_reg + 16'h0001;

   // Bus stalls may delay a start, so the bound has slack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg <= 1'b0;
         gap_reg  <= 16'h0000;
      end else begin
         busy_reg <= pass_busy;
         gap_reg  <= gap_next;
      end
   end

   // Read handshake steps
   sequence s_read_first;
      psel && penable && !pwrite && $rose(penable) && !pass_busy && !bad_a;
   endsequence
   sequence s_one_wait;
      !pready ##1 pready;
   endsequence

   a_read_wait: assert property (s_read_first |-> s_one_wait)
      else $error("read wait wrong");
   a_write_fast: assert property (psel && penable && pwrite &&
      $rose(penable) && !pass_busy |-> pready) else $error("write stalled");
   a_busy_holds: assert property (psel && penable && pass_busy
      |-> !pready) else $error("access inside pass");
   a_bad_addr: assert property (psel && penable && bad_a &&
      !pass_busy |-> pready && pslverr) else $error("bad address taken");
   a_good_addr: assert property (pready && !bad_a |-> !pslverr)
      else $error("error on good address");
   a_pass_len: assert property ($rose(pass_busy)
      |-> ##[1:25] !pass_busy) else $error("pass too long");
   a_tick_bound: assert property (gap_reg <= TICK_CYCLES + 30)
      else $error("pass missing");
   a_copy_gap: assert property (copy_valid |=> !copy_valid)
      else $error("copies too close");
   a_copy_window: assert property (copy_valid
      |-> pass_busy || $past(pass_busy)) else $error("copy outside pass");
   a_copy_target: assert property (copy_valid |-> copy_reg != 8'h00 &&
      copy_reg != 8'hff && copy_reg != 8'h6a) else $error("bad copy target");
   a_input_read: assert property (psel && penable && !pwrite && pready
      && !bad_a && paddr[9:2] == 8'h6a |-> prdata[31:16] == 16'h0000 &&
      (prdata[15:0] == input_state || prdata[15:0] == $past(input_state)))
      else $error("input state read wrong");
endmodule

bind irc_engine irc_engine_checker #(
   .ADDR_W(ADDR_W), .IN_W(IN_W), .TICK_CYCLES(TICK_CYCLES)
) i_irc_engine_checker (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .input_state(input_state), .pass_busy(pass_busy),
   .copy_valid(copy_valid), .copy_reg(copy_reg)
);

// ===== test/irc_engine_tb_top.sv
// Self-checking bench for the register copy engine
module irc_engine_tb_top import irc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        pass_busy;
   logic        copy_valid;
   logic [7:0]  copy_reg;
   irc_word_t   copy_data;
   logic [11:0] paddr;
   logic [15:0] input_state;
   irc_word_t   pwdata, prdata;
   int          bad_count, checks;
   // Fixed targets and group bases chosen for the design
   irc_regnum_t tgt[1:6]  = '{8'h02, 8'h05, 8'h03, 8'h06, 8'h07, 8'h21};
   irc_regnum_t base[1:6] = '{8'h58, 8'h70, 8'h30, 8'h78, 8'h80, 8'h88};

   irc_engine #(.TICK_CYCLES(64)) i_irc_engine (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_state(input_state), .pass_busy(pass_busy),
      .copy_valid(copy_valid), .copy_reg(copy_reg), .copy_data(copy_data)
   );

   // 25 MHz clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic finish_test;
      if (bad_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic stall_out;
      bad_count++;
      $display("wrong value at %0t: wait timed out", $time);
      finish_test;
   endtask

   task automatic chk(input irc_word_t got, input irc_word_t exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input irc_word_t wd, output irc_word_t rd,
                      output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (pready !== 1'b1) stall_out;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input irc_regnum_t r, input irc_word_t d);
      irc_word_t x;
      logic      e;
      apb(1'b1, {2'b00, r, 2'b00}, d, x, e);
   endtask

   task automatic rdchk(input irc_regnum_t r, input irc_word_t exp);
      irc_word_t x;
      logic      e;
      apb(1'b0, {2'b00, r, 2'b00}, 32'h0, x, e);
      chk(x, exp);
   endtask

   task automatic wait_lvl(input logic v);
      int n;
      n = 0;
      while (pass_busy !== v && n < 200) begin
         @(posedge pclk);
         n++;
      end
      if (pass_busy !== v) stall_out;
   endtask

   // Extra edge: a pass starting with the old inputs is skipped
   task automatic set_in(input logic [15:0] v);
      input_state <= v;
      @(posedge pclk);
   endtask

   task automatic wait_pass;
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
   endtask

   task automatic t_reset_vals;
      for (int n = 0; n < 12; n++) rdchk(8'h5d + 8'(n), 32'h0);
      wr(8'h5e, 32'hfffffff0);
      rdchk(8'h5e, 32'hfffffff0);
   endtask

   // Every fixed target code, both input levels, bit number equal to the code
   task automatic t_fixed_targets;
      wr(8'h40, 32'h0000dead);
      for (int k = 1; k < 7; k++) begin
         wr(base[k] + 8'h01, 32'(32'h100 + k));
         wr(base[k] + 8'h02, 32'(32'h200 + k));
         wr(8'h5d, {8'h40, 8'h01, 8'h02, 4'(k), 4'(k)});
         for (int v = 0; v < 2; v++) begin
            set_in(v ? 16'h1 << k : ~(16'h1 << k));
            wait_pass;
            rdchk(tgt[k], v ? 32'h100 + k : 32'h200 + k);
         end
      end
      rdchk(8'h40, 32'h0000dead);
   endtask

   task automatic t_zero_source;
      wr(8'h05, 32'h55);
      wr(8'h5d, 32'h00000112);
      set_in(16'h0002);
      wait_pass;
      rdchk(8'h05, 32'h55);
      set_in(16'h0000);
      wait_pass;
      rdchk(8'h05, 32'h102);
      // Index nine lies past the velocity group and must copy nothing
      wr(8'h5d, 32'h00000912);
      wait_pass;
      rdchk(8'h05, 32'h102);
   endtask

   task automatic t_indirect;
      wr(8'h41, 32'hcafe0001);
      wr(8'h42, 32'hcafe0002);
      wr(8'h5d, 32'h44414237);
      set_in(16'h0008);
      wait_pass;
      rdchk(8'h44, 32'hcafe0001);
      set_in(16'hfff7);
      wait_pass;
      rdchk(8'h44, 32'hcafe0002);
   endtask

   // Three rules on one bit and target; the last must stand
   task automatic t_priority;
      wr(8'h73, 32'h333);
      wr(8'h5d, 32'h00010152);
      wr(8'h62, 32'h00020252);
      wr(8'h68, 32'h00030352);
      set_in(16'h0020);
      wait_pass;
      // Last copy of the pass is rule eleven; its report pulses now
      chk({31'h0, copy_valid}, 32'h1);
      chk({24'h0, copy_reg}, 32'h05);
      chk(copy_data, 32'h333);
      rdchk(8'h05, 32'h333);
   endtask

   task automatic t_bus_edges;
      irc_word_t x;
      logic      e;
      apb(1'b1, 12'h404, 32'h1, x, e);
      chk({31'h0, e}, 32'h1);
      set_in(16'ha5c3);
      wr(8'h6a, 32'hffffffff);
      rdchk(8'h6a, 32'h0000a5c3);
      wait_lvl(1'b1);
      rdchk(8'h5e, 32'hfffffff0);
   endtask

   // Reset, then scenarios in order
   initial begin
      {psel, penable, pwrite} = 3'b000;
      paddr = 12'h000;
      pwdata = 32'h0;
      input_state = 16'h0000;
      presetn = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset_vals;
      t_fixed_targets;
      t_zero_source;
      t_indirect;
      t_priority;
      t_bus_edges;
      finish_test;
   end
endmodule
